// [core/hbc_pkg.sv]
package hbc_pkg;
  // bus widths
  localparam int HBC_DATA_W = 64;
  localparam int HBC_GRP_W = 16;
  localparam int HBC_NGRP = HBC_DATA_W / HBC_GRP_W;
  localparam int HBC_MAX_LOW = 8;
  // clock rates
  localparam int HBC_MCLK_MHZ = 200;
  localparam int HBC_BCLK_NS = 30;
  // processor reset extension, roughly 1 ms on the reference clock
  localparam int HBC_RST_EXT_US = 1000;
  localparam int HBC_RST_EXT_CYC = HBC_RST_EXT_US * HBC_MCLK_MHZ;
  // strap timing in bus clocks
  localparam int HBC_STRAP_SETUP = 4;
  localparam int HBC_STRAP_HOLD_MIN = 2;
  localparam int HBC_STRAP_HOLD_MAX = 20;
  localparam logic [4:0] HBC_STRAP_HOLD = 5'h0a;
  localparam logic [4:0] HBC_STRAP_SETUP_CNT = 5'h04;
  // data return warning lead in bus clocks
  localparam logic [3:0] HBC_DATA_POWER_N_LEAD = 4'h2;

  typedef enum logic [2:0] {
    HBC_IDLE = 3'h0,
    HBC_REQ_A = 3'h1,
    HBC_REQ_B = 3'h3,
    HBC_WAIT = 3'h2,
    HBC_DATA = 3'h6
  } hbc_state_t;

  // request from the core side
  typedef struct packed {
    logic snoop;
    logic int_msg;
    logic defer;
    logic retry;
  } hbc_req_t;

  // read data return from the core side
  typedef struct packed {
    logic valid;
    logic [HBC_DATA_W-1:0] data;
  } hbc_rdata_t;

  // link pin group (active low as on the wire)
  typedef struct packed {
    logic ads_n;
    logic priority_bus_req_n_n;
    logic data_bus_busy_n_n;
    logic data_valid_n_n;
    logic defer_n;
    logic data_power_n_n;
  } hbc_pins_t;
endpackage

// [core/hbc_inv.sv]
`timescale 1ns/100ps
module hbc_inv (
  // raw data
  input wire logic [hbc_pkg::HBC_DATA_W-1:0] data_i,
  // encoded wire value and flags
  output logic [hbc_pkg::HBC_DATA_W-1:0] host_data_n_o,
  output logic [hbc_pkg::HBC_NGRP-1:0] data_invert_flags_n_o
);
  import hbc_pkg::*;

  // count of zero bits in a group
  function automatic logic [4:0] zeros(input logic [HBC_GRP_W-1:0] g);
    logic [4:0] c;
    c = 5'h00;
    for (int k = 0; k < HBC_GRP_W; k++) begin
      c = c + {4'h0, ~g[k]};
    end
    return c;
  endfunction

  always_comb begin
    for (int i = 0; i < HBC_NGRP; i++) begin
      // data wire is inverted: a logical 1 drives electrically low
      logic [HBC_GRP_W-1:0] g;
      logic inv;
      g = data_i[i*HBC_GRP_W +: HBC_GRP_W];
      inv = (5'(HBC_GRP_W) - zeros(g)) > 5'(HBC_MAX_LOW);
      host_data_n_o[i*HBC_GRP_W +: HBC_GRP_W] = inv ? g : ~g;
      data_invert_flags_n_o[i] = ~inv;
    end
  end
endmodule // hbc_inv

// [core/hbc_ctrl.sv]
`timescale 1ns/100ps
// Overview of operation
// - bus owner strobes first request cycle
// - device strobes for snoops and interrupt messages
// - block-next-request stalls new requests
// - device is priority agent, requests address bus
// - bus request 0 low during processor reset
// - strap setup 4, hold 2 to 20
// - bus request 0 wakes input buffers
// - processor reset follows system reset plus 1ms
// - data owner holds busy until the last beat of a multi-cycle transfer
// - defer output signals deferred or retry
// - inversion flags keep low bits at most 8
// - deep sleep negation wakes host pll
// - data power warns 2 clocks before data
// - data valid in every transfer cycle
module hbc_ctrl #(
  parameter int RST_EXT_CYC = hbc_pkg::HBC_RST_EXT_CYC,
  parameter int BEATS = 4
) (
  // core clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // link clock
  input wire logic bclk_i,
  // system side
  input wire logic sys_reset_n_i,
  input wire logic deep_sleep_n_i,
  output logic host_pll_en_o,
  output logic in_buf_en_o,
  // core request side
  input wire hbc_pkg::hbc_req_t req_i,
  input wire hbc_pkg::hbc_rdata_t rdata_i,
  output logic req_ready_o,
  // link control pins
  output hbc_pkg::hbc_pins_t pins_o,
  input wire logic ads_n_i,
  input wire logic block_next_req_n_i,
  input wire logic bus_lock_n_i,
  output logic proc_reset_n_o,
  input wire logic sym_bus_req0_n_i,
  output logic sym_bus_req0_n_o,
  output logic sym_bus_req0_oe_o,
  // link data pins
  output logic [hbc_pkg::HBC_DATA_W-1:0] host_data_n_o,
  output logic [hbc_pkg::HBC_NGRP-1:0] data_invert_flags_n_o,
  output logic host_data_oe_o
);
  import hbc_pkg::*;

  // ************************
  // core domain state
  // ************************
  typedef struct packed {
    logic [1:0] srst_sync;
    logic [1:0] dslp_sync;
    logic [1:0] br0_sync;
    logic [31:0] ext_cnt;
    logic proc_rst;
    logic pll_en;
    logic req_tgl;
    logic [1:0] ack_sync;
    logic ack_seen;
    hbc_req_t req;
    hbc_rdata_t rd;
  } hbc_core_t;

  hbc_core_t c_ff;
  hbc_core_t nxt_c;
  logic ack_tgl_l;

  always_comb begin
    nxt_c = c_ff;
    nxt_c.srst_sync = {c_ff.srst_sync[0], sys_reset_n_i};
    nxt_c.dslp_sync = {c_ff.dslp_sync[0], deep_sleep_n_i};
    nxt_c.br0_sync = {c_ff.br0_sync[0], sym_bus_req0_n_i};
    nxt_c.ack_sync = {c_ff.ack_sync[0], ack_tgl_l};
    // reset extension restarts on every system reset
    if (!c_ff.srst_sync[1]) begin
      nxt_c.ext_cnt = 32'(RST_EXT_CYC);
      nxt_c.proc_rst = 1'b1;
    end else if (c_ff.ext_cnt != 32'h0) begin
      nxt_c.ext_cnt = c_ff.ext_cnt - 32'h1;
    end else begin
      nxt_c.proc_rst = 1'b0;
    end
    // negated deep sleep wakes the host pll
    if (c_ff.dslp_sync[1]) begin
      nxt_c.pll_en = 1'b1;
    end else begin
      nxt_c.pll_en = 1'b0;
    end
    // launch a request word by toggle handshake
    if (c_ff.ack_sync[1] == c_ff.req_tgl) begin
      nxt_c.ack_seen = 1'b1;
    end else begin
      nxt_c.ack_seen = 1'b0;
    end
    if (req_ready_o && !c_ff.proc_rst &&
        (|req_i || rdata_i.valid)) begin
      nxt_c.req = req_i;
      nxt_c.rd = rdata_i;
      nxt_c.req_tgl = ~c_ff.req_tgl;
      nxt_c.ack_seen = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      c_ff <= '0;
      // keep processor reset asserted straight out of reset, no release glitch
      c_ff.proc_rst <= 1'b1;
    end else begin
      c_ff <= nxt_c;
    end
  end

  assign req_ready_o = c_ff.ack_seen && (c_ff.ack_sync[1] == c_ff.req_tgl);
  assign host_pll_en_o = c_ff.pll_en;
  // bus request 0 low once core processor reset is released (strap hold included): power up input buffers
  assign in_buf_en_o = !c_ff.proc_rst && !c_ff.br0_sync[1];

  // ************************
  // link domain state
  // ************************
  typedef struct packed {
    logic [1:0] prst_sync;
    logic [1:0] req_sync;
    logic [1:0] bnr_sync;
    logic [1:0] lock_sync;
    logic prst;
    logic [4:0] strap_cnt;
    logic strap_drv;
    logic ack_tgl;
    hbc_state_t st;
    logic [3:0] cnt;
    logic ads;
    logic priority_bus_req_n;
    logic data_bus_busy_n;
    logic data_valid_n;
    logic defer;
    logic data_power_n;
    logic doe;
    logic [HBC_DATA_W-1:0] data;
  } hbc_link_t;

  hbc_link_t l_ff;
  hbc_link_t nxt_l;
  logic new_req;
  logic [HBC_DATA_W-1:0] enc_data;
  logic [HBC_NGRP-1:0] enc_flags;

  assign ack_tgl_l = l_ff.ack_tgl;
  // core word is stable while its toggle is outstanding
  assign new_req = l_ff.req_sync[1] != l_ff.ack_tgl;

  always_comb begin
    nxt_l = l_ff;
    nxt_l.prst_sync = {l_ff.prst_sync[0], c_ff.proc_rst};
    nxt_l.req_sync = {l_ff.req_sync[0], c_ff.req_tgl};
    nxt_l.bnr_sync = {l_ff.bnr_sync[0], block_next_req_n_i};
    nxt_l.lock_sync = {l_ff.lock_sync[0], bus_lock_n_i};
    nxt_l.prst = l_ff.prst_sync[1];
    nxt_l.ads = 1'b0;
    nxt_l.data_valid_n = 1'b0;
    nxt_l.defer = 1'b0;
    // strap: low for setup before and hold after reset release
    if (l_ff.prst_sync[1]) begin
      nxt_l.strap_drv = 1'b1;
      nxt_l.strap_cnt = HBC_STRAP_HOLD;
    end else if (l_ff.strap_cnt != 5'h00) begin
      nxt_l.strap_cnt = l_ff.strap_cnt - 5'h01;
    end else begin
      nxt_l.strap_drv = 1'b0;
    end
    case (l_ff.st)
      HBC_IDLE: begin
        if (new_req && !l_ff.prst) begin
          nxt_l.priority_bus_req_n = |{c_ff.req.snoop, c_ff.req.int_msg};
          nxt_l.st = HBC_REQ_A;
        end
      end
      HBC_REQ_A: begin
        // wait for block-next-request and lock to clear
        if (l_ff.bnr_sync[1] && l_ff.lock_sync[1]) begin
          nxt_l.ads = c_ff.req.snoop | c_ff.req.int_msg;
          nxt_l.defer = c_ff.req.defer | c_ff.req.retry;
          nxt_l.st = HBC_REQ_B;
        end
      end
      HBC_REQ_B: begin
        nxt_l.priority_bus_req_n = 1'b0;
        if (c_ff.rd.valid) begin
          nxt_l.data_power_n = 1'b1;
          nxt_l.cnt = HBC_DATA_POWER_N_LEAD;
          nxt_l.st = HBC_WAIT;
        end else begin
          nxt_l.ack_tgl = l_ff.req_sync[1];
          nxt_l.st = HBC_IDLE;
        end
      end
      HBC_WAIT: begin
        nxt_l.cnt = l_ff.cnt - 4'h1;
        if (l_ff.cnt == 4'h1) begin
          nxt_l.data_bus_busy_n = 1'b1;
          nxt_l.data_valid_n = 1'b1;
          nxt_l.doe = 1'b1;
          nxt_l.data = c_ff.rd.data;
          nxt_l.cnt = 4'(BEATS);
          nxt_l.st = HBC_DATA;
        end
      end
      HBC_DATA: begin
        nxt_l.cnt = l_ff.cnt - 4'h1;
        if (l_ff.cnt == 4'h1) begin
          nxt_l.data_bus_busy_n = 1'b0;
          nxt_l.data_power_n = 1'b0;
          nxt_l.doe = 1'b0;
          nxt_l.ack_tgl = l_ff.req_sync[1];
          nxt_l.st = HBC_IDLE;
        end else begin
          nxt_l.data_valid_n = 1'b1;
          nxt_l.data_bus_busy_n = l_ff.cnt > 4'h2;
        end
      end
      default: begin
        nxt_l.st = HBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge bclk_i or posedge rst_i) begin
    if (rst_i) begin
      l_ff <= '0;
      l_ff.prst_sync <= 2'h3;
      l_ff.prst <= 1'b1;
      l_ff.strap_drv <= 1'b1;
      l_ff.strap_cnt <= HBC_STRAP_HOLD;
      l_ff.st <= HBC_IDLE;
    end else begin
      l_ff <= nxt_l;
    end
  end

  // ************************
  // data encoding and pins
  // ************************
  hbc_inv i_hbc_inv (
    .data_i(l_ff.data),
    .host_data_n_o(enc_data),
    .data_invert_flags_n_o(enc_flags)
  );

  assign host_data_n_o = enc_data;
  assign data_invert_flags_n_o = enc_flags;
  assign host_data_oe_o = l_ff.doe;
  assign proc_reset_n_o = ~l_ff.prst;
  assign sym_bus_req0_n_o = 1'b0;
  assign sym_bus_req0_oe_o = l_ff.strap_drv;
  assign pins_o.ads_n = ~l_ff.ads;
  assign pins_o.priority_bus_req_n_n = ~l_ff.priority_bus_req_n;
  assign pins_o.data_bus_busy_n_n = ~l_ff.data_bus_busy_n;
  assign pins_o.data_valid_n_n = ~l_ff.data_valid_n;
  assign pins_o.defer_n = ~l_ff.defer;
  assign pins_o.data_power_n_n = ~l_ff.data_power_n;
endmodule // hbc_ctrl

// [verif/hbc_ctrl_asserts.sv]
`timescale 1ns/100ps
module hbc_ctrl_asserts #(parameter int BEATS = 4) (
  // clocks
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic bclk_i,
  // watched
  input wire logic sys_reset_n_i,
  input wire logic deep_sleep_n_i,
  input wire logic host_pll_en_o,
  input wire hbc_pkg::hbc_pins_t pins_o,
  input wire logic block_next_req_n_i,
  input wire logic bus_lock_n_i,
  input wire logic proc_reset_n_o,
  input wire logic sym_bus_req0_oe_o,
  input wire logic [hbc_pkg::HBC_DATA_W-1:0] host_data_n_o,
  input wire logic host_data_oe_o
);
  import hbc_pkg::*;
  // ****
  // beat count
  // ****
  logic [7:0] beat_ff;
  always_ff @(posedge bclk_i or posedge rst_i) begin
    if (rst_i) begin
      beat_ff <= 8'h00;
    end else begin
      beat_ff <= pins_o.data_valid_n_n ? 8'h00 : beat_ff + 8'h01;
    end
  end
  function automatic logic lows_ok(input logic [HBC_DATA_W-1:0] d);
    for (int g = 0; g < HBC_NGRP; g++) begin
      if ($countones(~d[g*HBC_GRP_W+:HBC_GRP_W]) > HBC_MAX_LOW) return 1'b0;
    end
    return 1'b1;
  endfunction
  // ****
  // checks
  // ****
  AST_STRAP_RST: assert property (@(posedge bclk_i) disable iff (rst_i)
    !proc_reset_n_o |-> sym_bus_req0_oe_o) else $error("strap off in reset");
  AST_STRAP_HOLD: assert property (@(posedge bclk_i) disable iff (rst_i)
    $rose(proc_reset_n_o) |-> ($past(sym_bus_req0_oe_o, 4) && sym_bus_req0_oe_o)
    ##1 sym_bus_req0_oe_o ##[1:18] !sym_bus_req0_oe_o) else $error("strap timing");
  AST_PROC_RESET_N_ON: assert property (@(posedge mclk_i) disable iff (rst_i)
    !sys_reset_n_i |-> ##[0:40] !proc_reset_n_o) else $error("proc reset late");
  AST_PROC_RESET_N_EXT: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(sys_reset_n_i) |-> !proc_reset_n_o [*8]) else $error("proc reset short");
  AST_ADS_PRI: assert property (@(posedge bclk_i) disable iff (rst_i)
    $fell(pins_o.ads_n) |-> !$past(pins_o.priority_bus_req_n_n) ##1 pins_o.ads_n) else $error("strobe");
  AST_BNR: assert property (@(posedge bclk_i) disable iff (rst_i)
    (!block_next_req_n_i || !bus_lock_n_i) [*5] |-> pins_o.ads_n) else $error("not blocked");
  AST_DEFER: assert property (@(posedge bclk_i) disable iff (rst_i)
    $fell(pins_o.defer_n) |=> pins_o.defer_n) else $error("defer width");
  AST_DATA_POWER_N: assert property (@(posedge bclk_i) disable iff (rst_i)
    $fell(pins_o.data_valid_n_n) |-> !pins_o.data_power_n_n && !$past(pins_o.data_power_n_n, 2)) else $error("lead");
  AST_BEATS: assert property (@(posedge bclk_i) disable iff (rst_i)
    $rose(pins_o.data_valid_n_n) |-> beat_ff == 8'(BEATS)) else $error("beat count");
  AST_DATA_BUS_BUSY_N: assert property (@(posedge bclk_i) disable iff (rst_i)
    !pins_o.data_valid_n_n |-> host_data_oe_o && (pins_o.data_bus_busy_n_n == (beat_ff == 8'(BEATS - 1))))
    else $error("busy");
  AST_DINV: assert property (@(posedge bclk_i) disable iff (rst_i)
    host_data_oe_o |-> lows_ok(host_data_n_o)) else $error("too many lows");
  AST_PLL: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(deep_sleep_n_i) |-> ##[1:4] host_pll_en_o) else $error("pll wake");
  cover property (@(posedge bclk_i) $fell(pins_o.ads_n));
  cover property (@(posedge bclk_i) $fell(pins_o.data_valid_n_n));
  cover property (@(posedge bclk_i) $rose(proc_reset_n_o));
endmodule // hbc_ctrl_asserts
bind hbc_ctrl hbc_ctrl_asserts #(.BEATS(BEATS)) i_hbc_ctrl_asserts (.mclk_i, .rst_i, .bclk_i,
  .sys_reset_n_i, .deep_sleep_n_i, .host_pll_en_o, .pins_o, .block_next_req_n_i, .bus_lock_n_i,
  .proc_reset_n_o, .sym_bus_req0_oe_o, .host_data_n_o, .host_data_oe_o);

// [verif/hbc_cpu_model.sv]
`timescale 1ns/100ps
module hbc_cpu_model (
  // link
  input wire logic bclk_i,
  input wire hbc_pkg::hbc_pins_t pins_i,
  input wire logic proc_reset_n_i,
  input wire logic req0_drv_n_i,
  input wire logic req0_oe_i,
  // bench control
  input wire logic stall_i,
  input wire logic lock_i,
  input wire logic want_i,
  // to device
  output logic bnr_n_o,
  output logic lock_n_o,
  output logic ads_n_o,
  output logic req0_n_o,
  output logic strap_o,
  output logic buf_on_o
);
  logic seen_ff;
  initial begin
    bnr_n_o = 1'b1;
    lock_n_o = 1'b1;
    ads_n_o = 1'b1;
    strap_o = 1'b1;
    seen_ff = 1'b0;
  end
  // released wire floats to the pull-up unless the processor asks for the bus
  assign req0_n_o = req0_oe_i ? req0_drv_n_i : !want_i;
  assign buf_on_o = !pins_i.data_power_n_n;
  always @(posedge bclk_i) begin
    bnr_n_o <= !stall_i;
    lock_n_o <= !lock_i;
    ads_n_o <= !(want_i && ads_n_o && (pins_i.priority_bus_req_n_n || !lock_n_o));
    seen_ff <= proc_reset_n_i;
    if (proc_reset_n_i && !seen_ff) strap_o <= req0_n_o;
  end
endmodule // hbc_cpu_model

// [verif/hbc_ctrl_tb_top.sv]
`timescale 1ns/100ps
module hbc_ctrl_tb_top;
  import hbc_pkg::*;
  localparam int EXT = 20;
  localparam int BEATS = 4;
  localparam logic [63:0] DAT = 64'hffff_0000_00ff_0f0f;
  logic mclk_i = 1'b0, bclk_i = 1'b0, rst_i = 1'b1, sys_reset_n_i = 1'b0, deep_sleep_n_i = 1'b1;
  hbc_req_t req_i = '0;
  hbc_rdata_t rdata_i = '0;
  logic stall = 1'b0, lock = 1'b0, want = 1'b0, strap;
  logic host_pll_en_o, in_buf_en_o, req_ready_o, ads_n_i, block_next_req_n_i, bus_lock_n_i;
  logic proc_reset_n_o, sym_bus_req0_n_i, sym_bus_req0_n_o, sym_bus_req0_oe_o, host_data_oe_o;
  hbc_pins_t pins_o;
  logic [63:0] host_data_n_o, got;
  logic [3:0] data_invert_flags_n_o;
  int error_cnt = 0, n_checks = 0, w_n, n_ads, n_def, n_beat, n_pri;
  hbc_ctrl #(.RST_EXT_CYC(EXT), .BEATS(BEATS)) i_hbc_ctrl (.mclk_i, .rst_i, .bclk_i,
    .sys_reset_n_i, .deep_sleep_n_i, .host_pll_en_o, .in_buf_en_o, .req_i, .rdata_i,
    .req_ready_o, .pins_o, .ads_n_i, .block_next_req_n_i, .bus_lock_n_i, .proc_reset_n_o,
    .sym_bus_req0_n_i, .sym_bus_req0_n_o, .sym_bus_req0_oe_o, .host_data_n_o,
    .data_invert_flags_n_o, .host_data_oe_o);
  hbc_cpu_model i_hbc_cpu_model (.bclk_i, .pins_i(pins_o), .proc_reset_n_i(proc_reset_n_o),
    .req0_drv_n_i(sym_bus_req0_n_o), .req0_oe_i(sym_bus_req0_oe_o), .stall_i(stall),
    .lock_i(lock), .want_i(want), .bnr_n_o(block_next_req_n_i), .lock_n_o(bus_lock_n_i),
    .ads_n_o(ads_n_i), .req0_n_o(sym_bus_req0_n_i), .strap_o(strap), .buf_on_o());
  initial forever #2.5 mclk_i = ~mclk_i;
  initial begin
    #2;
    forever begin
      bclk_i = ~bclk_i;
      #15;
    end
  end
  always @(negedge bclk_i) begin
    if (!pins_o.ads_n) n_ads++;
    if (!pins_o.defer_n) n_def++;
    if (!pins_o.priority_bus_req_n_n) n_pri++;
    if (!pins_o.data_valid_n_n) begin
      n_beat++;
      for (int g = 0; g < 4; g++) begin
        got[g*16+:16] = host_data_n_o[g*16+:16];
        if (data_invert_flags_n_o[g]) got[g*16+:16] = ~host_data_n_o[g*16+:16];
      end
    end
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task check(input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic cond(input int s);
    case (s)
      0: return proc_reset_n_o;
      1: return in_buf_en_o;
      2: return req_ready_o;
      3: return !req_ready_o;
      4: return host_pll_en_o;
      5: return !host_pll_en_o;
      default: return !sym_bus_req0_oe_o;
    endcase
  endfunction
  task wait_for(input int s);
    w_n = 0;
    do begin
      @(negedge mclk_i);
      w_n++;
    end while (cond(s) !== 1'b1 && w_n < 4000);
    if (cond(s) !== 1'b1) begin
      error_cnt++;
      wrap_up;
    end
  endtask
  task issue(input hbc_req_t r, input hbc_rdata_t d);
    wait_for(2);
    @(posedge mclk_i) begin
      req_i <= r;
      rdata_i <= d;
    end
    @(posedge mclk_i) begin
      req_i <= '0;
      rdata_i <= '0;
    end
  endtask
  task done;
    wait_for(3);
    wait_for(2);
  endtask
  task t_reset;
    #5;
    check(proc_reset_n_o, 0);
    check(sym_bus_req0_oe_o, 1);
    check(pins_o, 64'h3f);
    check(req_ready_o, 0);
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    sys_reset_n_i <= 1'b1;
    wait_for(0);
    check(w_n >= EXT && w_n <= EXT + 40, 1);
    repeat (2) @(posedge bclk_i);
    check(strap, 0);
    wait_for(6);
    repeat (6) @(negedge mclk_i);
    check(in_buf_en_o, 0);
    @(posedge mclk_i) want <= 1'b1;
    wait_for(1);
    check(w_n <= 4, 1);
    @(posedge mclk_i) want <= 1'b0;
    $display("test reset done");
  endtask
  task t_req;
    for (int k = 0; k < 4; k++) begin
      n_ads = 0;
      n_def = 0;
      n_pri = 0;
      issue(hbc_req_t'(4'h1 << k), '0);
      done;
      check(n_ads, k > 1);
      check(n_def, k < 2);
      check(n_pri > 0, k > 1);
    end
    n_beat = 0;
    issue('0, {1'b1, DAT});
    done;
    check(n_beat, BEATS);
    check(got, DAT);
    $display("test request done");
  endtask
  task t_block;
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk_i) begin
        stall <= !k;
        lock <= k;
      end
      n_ads = 0;
      issue(hbc_req_t'(4'h8), '0);
      repeat (60) @(negedge mclk_i);
      check(n_ads, 0);
      @(posedge mclk_i) begin
        stall <= 1'b0;
        lock <= 1'b0;
      end
      done;
      check(n_ads, 1);
    end
    $display("test block done");
  endtask
  task t_sleep;
    @(posedge mclk_i) deep_sleep_n_i <= 1'b0;
    wait_for(5);
    @(posedge mclk_i) deep_sleep_n_i <= 1'b1;
    wait_for(4);
    check(w_n <= 5, 1);
    $display("test sleep done");
  endtask
  initial begin
    t_reset;
    t_req;
    t_block;
    t_sleep;
    wrap_up;
  end
endmodule // hbc_ctrl_tb_top
